//--- src/ipp_pkg.sv
// Shared constants and types for the instruction prefetch pipeline.
// Assumes a 16-bit word machine whose instruction stream advances by bytes.
package ipp_pkg;

  // Default widths and buffer depth
  localparam int DATA_W_DEF    = 16;
  localparam int PADDR_W_DEF   = 22;
  localparam int BUF_DEPTH_DEF = 2;

  // Byte step between instruction stream words
  localparam int WORD_STEP = 2;

  // Values after reset
  localparam int PC_RESET   = 0;
  localparam int WORD_RESET = 0;

  // Freeze field of the memory-management control word
  localparam int          FREEZE_MSB  = 15;
  localparam int          FREEZE_LSB  = 13;
  localparam logic [2:0]  FREEZE_OPEN = 3'h0;

  // Fill progress of the prefetch pipeline
  typedef enum logic [1:0] {
    IPP_UNSYNC,   // Needs the counter copy
    IPP_XLATE,    // Needs the first translation
    IPP_NOPB,     // Synchronized, buffer word missing
    IPP_FULL      // Buffer word valid
  } ipp_fill_t;

endpackage

//--- src/ipp_prefetch.sv
// Instruction prefetch and predecode pipeline: counter, physical address,
// buffer word and decode word, plus a two-entry output buffer.
// Assumes a combinational address translator and a memory that returns the
// addressed word in the cycle it accepts the fetch; mem_rdy must not depend
// on bus_fetch. One clock edge is one microcycle.
// A prefetch fault rewinds the counters one word so that the refill rebuilds
// the dropped buffer word; a write that moves the flow of control to a
// new address must be followed by restart, which resynchronizes.
// A full output buffer refuses steps rather than dropping a word.
//
// Contract
// RULE1 - An empty pipeline fills in four consecutive microcycles.
// RULE2 - The first fill microcycle copies the program counter into the virtual fetch counter.
// RULE3 - The second translates the counter into the physical address and steps the counter by 2.
// RULE4 - A synchronized but unfilled pipeline runs only fill microcycles three and four.
// RULE5 - The third fetches the buffer word, retranslates the address and steps the counter.
// RULE6 - The fourth moves the buffer word into the decode word and raises the predecode strobe.
// RULE7 - The fourth also refetches the buffer, retranslates the address and steps the counter.
// RULE8 - The fourth snapshots the program counter when the freeze field is zero, then adds 2.
// RULE9 - In steady state the registers hold instruction, next word, next address, next counter.
// RULE10 - Register-only instructions advance one per microcycle with decode and prefetch overlapped.
// RULE11 - A stream of such instructions fetches on the bus in every microcycle.
// RULE12 - Immediate operands take a scratch move then an operate step, both still prefetching.
// RULE13 - The pipeline refills after power-up and after any prefetch fault.
// RULE14 - Writes to status word, cache control, program counter or mapping registers fault.
// RULE15 - A fault drops only the buffer word and refills in two microcycles.
// RULE16 - Reset leaves the pipeline empty and unsynchronized.
`timescale 1ns/10ps
module ipp_prefetch #(
  parameter int DATA_W    = ipp_pkg::DATA_W_DEF,
  parameter int PADDR_W   = ipp_pkg::PADDR_W_DEF,
  parameter int BUF_DEPTH = ipp_pkg::BUF_DEPTH_DEF
) (
  input  wire logic               core_clk,
  input  wire logic               rst_b,
  input  wire logic               restart,
  input  wire logic [DATA_W-1:0]  restart_pc,
  input  wire logic               adv_decode,
  input  wire logic               adv_imm,
  output logic                    step_ack,
  input  wire logic               wr_psw,
  input  wire logic               wr_ccr,
  input  wire logic               wr_pc,
  input  wire logic               wr_mmu,
  input  wire logic [DATA_W-1:0]  pc_wr_data,
  input  wire logic [15:0]        mmu_control_status,
  output logic [DATA_W-1:0]       mmu_vaddr,
  input  wire logic [PADDR_W-1:0] mmu_paddr,
  output logic                    bus_fetch,
  output logic [PADDR_W-1:0]      bus_addr,
  input  wire logic               mem_rdy,
  input  wire logic [DATA_W-1:0]  mem_rdata,
  output logic                    predecode_strobe,
  output logic                    pipe_synced,
  output logic                    pipe_steady,
  output logic [DATA_W-1:0]       pc,
  output logic [DATA_W-1:0]       fault_pc_snapshot_reg,
  output logic [DATA_W-1:0]       decode_holding_word,
  output logic [DATA_W-1:0]       scratch_word,
  output logic                    out_valid,
  input  wire logic               out_ready,
  output logic [DATA_W-1:0]       out_word,
  output logic                    out_is_imm
);

  localparam int PTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  localparam int CNT_W = PTR_W + 1;

  // Refuse shapes the logic cannot serve
  if (DATA_W < 16 || DATA_W > 32) begin : g_bad_data_w
    $error("ipp_prefetch: DATA_W must lie in 16..32");
  end
  if (PADDR_W < DATA_W) begin : g_bad_paddr_w
    $error("ipp_prefetch: PADDR_W must not be below DATA_W");
  end
  if (BUF_DEPTH < 2 || (BUF_DEPTH & (BUF_DEPTH - 1)) != 0) begin : g_bad_depth
    $error("ipp_prefetch: BUF_DEPTH must be a power of two, at least 2");
  end

  // Next sequential instruction stream address
  function automatic logic [DATA_W-1:0] step_word(input logic [DATA_W-1:0] a);
    step_word = a + DATA_W'(ipp_pkg::WORD_STEP);
  endfunction

  // Previous instruction stream address, used to rewind after a fault
  function automatic logic [DATA_W-1:0] back_word(input logic [DATA_W-1:0] a);
    back_word = a - DATA_W'(ipp_pkg::WORD_STEP);
  endfunction

  // Pipeline state
  ipp_pkg::ipp_fill_t  fill_st;
  ipp_pkg::ipp_fill_t  next_fill_st;
  logic [DATA_W-1:0]   virtual_fetch_counter;
  logic [DATA_W-1:0]   next_virtual_fetch_counter;
  logic [PADDR_W-1:0]  physical_fetch_address;
  logic [PADDR_W-1:0]  next_physical_fetch_address;
  logic [DATA_W-1:0]   prefetch_buffer;
  logic [DATA_W-1:0]   next_prefetch_buffer;
  logic [DATA_W-1:0]   next_decode_holding_word;
  logic [DATA_W-1:0]   next_scratch_word;
  logic [DATA_W-1:0]   next_pc;
  logic [DATA_W-1:0]   next_fault_pc_snapshot_reg;
  // Physical address of the word now held in the buffer
  logic [PADDR_W-1:0]  pb_paddr;
  logic [PADDR_W-1:0]  next_pb_paddr;
  // Decode word valid since the last restart
  logic                ir_valid;
  logic                next_ir_valid;

  // Output buffer state
  logic [DATA_W:0]     buf_mem [BUF_DEPTH];
  logic [DATA_W:0]     next_buf_mem [BUF_DEPTH];
  logic [PTR_W-1:0]    wr_ptr;
  logic [PTR_W-1:0]    next_wr_ptr;
  logic [PTR_W-1:0]    rd_ptr;
  logic [PTR_W-1:0]    next_rd_ptr;
  logic [CNT_W-1:0]    buf_count;
  logic [CNT_W-1:0]    next_buf_count;

  // Decisions of this microcycle
  logic                fault;
  logic                buf_full;
  logic                want_fill3;
  logic                want_step;
  logic                fill3;
  logic                do_dec;
  logic                do_imm;
  logic                push;
  logic                pop;
  logic [DATA_W:0]     push_entry;

  // Fault sources and fetch requests
  always_comb begin
    fault      = wr_psw | wr_ccr | wr_pc | wr_mmu;                 // RULE14
    // A full output buffer refuses the step so that no word is lost
    buf_full   = (buf_count == CNT_W'(BUF_DEPTH));
    want_fill3 = (fill_st == ipp_pkg::IPP_NOPB) && !fault && !restart;   // RULE4
    want_step  = (fill_st == ipp_pkg::IPP_FULL) && !fault && !restart &&
                 (adv_decode || adv_imm) && !buf_full;
    bus_fetch  = want_fill3 || want_step;                          // RULE11
    fill3      = want_fill3 && mem_rdy;
    do_dec     = want_step && mem_rdy && adv_decode;               // RULE10
    do_imm     = want_step && mem_rdy && !adv_decode;              // RULE12
    // Either step kind is acknowledged in the cycle it is taken
    step_ack   = do_dec || do_imm;
  end

  // Fill sequence, steady flow and fault recovery
  always_comb begin
    next_fill_st                = fill_st;
    next_virtual_fetch_counter  = virtual_fetch_counter;
    next_physical_fetch_address = physical_fetch_address;
    next_prefetch_buffer        = prefetch_buffer;
    next_decode_holding_word    = decode_holding_word;
    next_scratch_word           = scratch_word;
    next_pc                     = pc;
    next_fault_pc_snapshot_reg  = fault_pc_snapshot_reg;
    next_pb_paddr               = pb_paddr;
    next_ir_valid               = ir_valid;
    // Restart beats a fault in the same cycle
    if (restart) begin
      // New flow of control: start again from the counter copy
      next_pc       = restart_pc;
      next_fill_st  = ipp_pkg::IPP_UNSYNC;
      next_ir_valid = 1'b0;
    end else if (fault) begin
      // Drop only the buffer word, keep synchronization
      if (wr_pc) begin
        next_pc = pc_wr_data;
      end
      // Unfilled states hold for this microcycle and resume the fill after it
      if (fill_st == ipp_pkg::IPP_FULL) begin
        // Point the fetch back at the dropped word so the refill rebuilds it
        next_physical_fetch_address = pb_paddr;                    // RULE15
        next_virtual_fetch_counter  = back_word(virtual_fetch_counter);
        next_fill_st = ipp_pkg::IPP_NOPB;                          // RULE15
      end
    end else begin
      unique case (fill_st)
        ipp_pkg::IPP_UNSYNC: begin
          next_virtual_fetch_counter = pc;                         // RULE2
          next_fill_st               = ipp_pkg::IPP_XLATE;         // RULE1
        end
        ipp_pkg::IPP_XLATE: begin
          next_physical_fetch_address = mmu_paddr;                 // RULE3
          next_virtual_fetch_counter  = step_word(virtual_fetch_counter);
          next_fill_st                = ipp_pkg::IPP_NOPB;         // RULE4
        end
        ipp_pkg::IPP_NOPB: begin
          // Memory not ready: ask again next microcycle
          if (fill3) begin
            next_prefetch_buffer        = mem_rdata;               // RULE5
            next_pb_paddr               = physical_fetch_address;
            next_physical_fetch_address = mmu_paddr;
            next_virtual_fetch_counter  = step_word(virtual_fetch_counter);
            next_fill_st                = ipp_pkg::IPP_FULL;       // RULE13
          end
        end
        ipp_pkg::IPP_FULL: begin
          if (step_ack) begin
            // Both step kinds keep the prefetch going
            next_prefetch_buffer        = mem_rdata;               // RULE7
            next_pb_paddr               = physical_fetch_address;
            next_physical_fetch_address = mmu_paddr;               // RULE9
            next_virtual_fetch_counter  = step_word(virtual_fetch_counter);
            next_pc                     = step_word(pc);           // RULE8
          end
          if (do_dec) begin
            next_decode_holding_word = prefetch_buffer;            // RULE6
            next_ir_valid            = 1'b1;
            // Snapshot only while the freeze field is open
            if (mmu_control_status[ipp_pkg::FREEZE_MSB:ipp_pkg::FREEZE_LSB] ==
                ipp_pkg::FREEZE_OPEN) begin
              next_fault_pc_snapshot_reg = pc;                     // RULE8
            end
          end
          if (do_imm) begin
            next_scratch_word = prefetch_buffer;                   // RULE12
          end
        end
      endcase
    end
  end

  // Pipeline registers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fill_st                <= ipp_pkg::IPP_UNSYNC;               // RULE16
      virtual_fetch_counter  <= DATA_W'(ipp_pkg::PC_RESET);
      physical_fetch_address <= PADDR_W'(ipp_pkg::PC_RESET);
      prefetch_buffer        <= DATA_W'(ipp_pkg::WORD_RESET);
      decode_holding_word    <= DATA_W'(ipp_pkg::WORD_RESET);
      scratch_word           <= DATA_W'(ipp_pkg::WORD_RESET);
      pc                     <= DATA_W'(ipp_pkg::PC_RESET);
      fault_pc_snapshot_reg  <= DATA_W'(ipp_pkg::PC_RESET);
      pb_paddr               <= PADDR_W'(ipp_pkg::PC_RESET);
      ir_valid               <= 1'b0;                              // RULE16
    end else begin
      fill_st                <= next_fill_st;
      virtual_fetch_counter  <= next_virtual_fetch_counter;
      physical_fetch_address <= next_physical_fetch_address;
      prefetch_buffer        <= next_prefetch_buffer;
      decode_holding_word    <= next_decode_holding_word;
      scratch_word           <= next_scratch_word;
      pc                     <= next_pc;
      fault_pc_snapshot_reg  <= next_fault_pc_snapshot_reg;
      pb_paddr               <= next_pb_paddr;
      ir_valid               <= next_ir_valid;
    end
  end

  // Status and pin views of the pipeline
  always_comb begin
    predecode_strobe = do_dec;                                     // RULE6
    mmu_vaddr        = virtual_fetch_counter;
    bus_addr         = physical_fetch_address;
    pipe_synced      = (fill_st == ipp_pkg::IPP_NOPB) || (fill_st == ipp_pkg::IPP_FULL);
    pipe_steady      = (fill_st == ipp_pkg::IPP_FULL) && ir_valid; // RULE9
  end

  // Output buffer: decoded words and immediates toward the engine
  always_comb begin
    push       = step_ack;
    pop        = out_valid && out_ready;
    push_entry = {do_imm, prefetch_buffer};
    next_buf_mem = buf_mem;
    next_wr_ptr  = wr_ptr;
    next_rd_ptr  = rd_ptr;
    // Push and pop may share a cycle; the count then holds
    if (push) begin
      next_buf_mem[wr_ptr] = push_entry;
      next_wr_ptr          = wr_ptr + PTR_W'(1);
    end
    if (pop) begin
      next_rd_ptr = rd_ptr + PTR_W'(1);
    end
    next_buf_count = buf_count + CNT_W'(push) - CNT_W'(pop);
  end

  // Output buffer registers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      // Storage resets too, so the head never shows unknown data
      for (int i = 0; i < BUF_DEPTH; i++) begin
        buf_mem[i] <= '0;
      end
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      buf_count <= '0;
    end else begin
      buf_mem   <= next_buf_mem;
      wr_ptr    <= next_wr_ptr;
      rd_ptr    <= next_rd_ptr;
      buf_count <= next_buf_count;
    end
  end

  // Head of the output buffer
  always_comb begin
    out_valid  = (buf_count != '0);
    out_word   = buf_mem[rd_ptr][DATA_W-1:0];
    // Immediate words carry their flag in the top bit
    out_is_imm = buf_mem[rd_ptr][DATA_W];
  end

endmodule

//--- tb/ipp_mem_model.sv
// Memory and address translator model facing the prefetch bus.
// Assumes a combinational translator and a memory answering in one cycle.
`timescale 1ns/10ps
module ipp_mem_model (
  input  wire logic        slow,
  input  wire logic [15:0] mmu_vaddr,
  output logic      [21:0] mmu_paddr,
  input  wire logic [21:0] bus_addr,
  output logic             mem_rdy,
  output logic      [15:0] mem_rdata
);
  // Fixed page offset keeps the mapping visible on the address
  assign mmu_paddr = {6'h01, mmu_vaddr};
  // Ready ignores the fetch strobe; data is inverted while not ready
  assign mem_rdy   = !slow;
  assign mem_rdata = mem_rdy ? bus_addr[15:0] ^ 16'h5a5a : ~(bus_addr[15:0] ^ 16'h5a5a);
endmodule

//--- tb/ipp_prefetch_assertions.sv
// Checker for the prefetch pipeline, bound to every ipp_prefetch instance.
// Assumes one clock domain and the asynchronous active-low reset of the block.
`timescale 1ns/10ps
module ipp_chk #(
  parameter int DATA_W  = 16,
  parameter int PADDR_W = 22
) (
  input wire logic               core_clk,
  input wire logic               rst_b,
  input wire logic               restart,
  input wire logic               adv_decode,
  input wire logic               step_ack,
  input wire logic               wr_psw,
  input wire logic               wr_ccr,
  input wire logic               wr_pc,
  input wire logic               wr_mmu,
  input wire logic [15:0]        mmu_control_status,
  input wire logic [DATA_W-1:0]  mmu_vaddr,
  input wire logic [PADDR_W-1:0] mmu_paddr,
  input wire logic               bus_fetch,
  input wire logic [PADDR_W-1:0] bus_addr,
  input wire logic               mem_rdy,
  input wire logic               predecode_strobe,
  input wire logic               pipe_synced,
  input wire logic               pipe_steady,
  input wire logic [DATA_W-1:0]  pc,
  input wire logic [DATA_W-1:0]  fault_pc_snapshot_reg,
  input wire logic               out_valid
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // Any register write that faults the prefetch
  logic flt;
  assign flt = wr_psw | wr_ccr | wr_pc | wr_mmu;
  // Fill order, step effects, snapshot and fault recovery
  property p_fill; $rose(rst_b) |-> !pipe_synced ##1 !pipe_synced ##1 pipe_synced && bus_fetch;
  endproperty
  property p_unsync; !pipe_synced |-> !step_ack; endproperty
  property p_strobe; predecode_strobe |-> step_ack && adv_decode && bus_fetch; endproperty
  property p_fetch; bus_fetch && mem_rdy && pipe_synced && !restart && !flt |=>
    (mmu_vaddr - $past(mmu_vaddr)) == DATA_W'(2) && bus_addr == $past(mmu_paddr); endproperty
  property p_pc; step_ack |=> (pc - $past(pc)) == DATA_W'(2); endproperty
  property p_snap; predecode_strobe && mmu_control_status[15:13] == 3'h0 |=>
    fault_pc_snapshot_reg == $past(pc); endproperty
  property p_frozen; predecode_strobe && mmu_control_status[15:13] != 3'h0 |=>
    $stable(fault_pc_snapshot_reg); endproperty
  property p_fault; flt && pipe_steady && !restart |->
    !step_ack ##1 pipe_synced && !pipe_steady && (bus_fetch || flt || restart); endproperty
  property p_push; step_ack |=> out_valid; endproperty
  a_fill: assert property (p_fill) else $error("fill order wrong");
  a_unsync: assert property (p_unsync) else $error("step while unsynced");
  a_strobe: assert property (p_strobe) else $error("strobe without decode step");
  a_fetch: assert property (p_fetch) else $error("fetch counters wrong");
  a_pc: assert property (p_pc) else $error("pc step wrong");
  a_snap: assert property (p_snap) else $error("snapshot not taken");
  a_frozen: assert property (p_frozen) else $error("snapshot changed");
  a_fault: assert property (p_fault) else $error("fault recovery wrong");
  a_push: assert property (p_push) else $error("step word lost");
  c_dec: cover property (predecode_strobe);
  c_imm: cover property (step_ack && !adv_decode);
  c_flt: cover property (flt && pipe_steady);
endmodule
bind ipp_prefetch ipp_chk #(.DATA_W(DATA_W), .PADDR_W(PADDR_W)) i_chk (
  .core_clk(core_clk), .rst_b(rst_b), .restart(restart), .adv_decode(adv_decode),
  .step_ack(step_ack), .wr_psw(wr_psw), .wr_ccr(wr_ccr), .wr_pc(wr_pc), .wr_mmu(wr_mmu),
  .mmu_control_status(mmu_control_status), .mmu_vaddr(mmu_vaddr), .mmu_paddr(mmu_paddr),
  .bus_fetch(bus_fetch), .bus_addr(bus_addr), .mem_rdy(mem_rdy),
  .predecode_strobe(predecode_strobe), .pipe_synced(pipe_synced),
  .pipe_steady(pipe_steady), .pc(pc), .fault_pc_snapshot_reg(fault_pc_snapshot_reg),
  .out_valid(out_valid)
);

//--- tb/testbench.sv
// Self-checking bench for the prefetch pipeline with its memory model.
// Assumes the package, design, model and checker are compiled before it.
`timescale 1ns/10ps
module testbench;
  logic        core_clk = 0, rst_b = 0, restart = 0, adv_decode = 0, adv_imm = 0;
  logic        wr_psw = 0, wr_ccr = 0, wr_pc = 0, wr_mmu = 0, slow = 0, out_ready = 1;
  logic [15:0] restart_pc = 16'h0, pc_wr_data = 16'h0, mmu_control_status = 16'h0;
  logic [15:0] exp_dec = 16'h0, exp_snap = 16'h0, p;
  logic        step_ack, bus_fetch, predecode_strobe, pipe_synced, pipe_steady;
  logic        out_valid, out_is_imm, mem_rdy;
  logic [15:0] mmu_vaddr, mem_rdata, pc, fault_pc_snapshot_reg, decode_holding_word;
  logic [15:0] scratch_word, out_word;
  logic [21:0] mmu_paddr, bus_addr;
  int          fails = 0, samples_checked = 0, cycles = 0;
  ipp_prefetch i_dut (
    .core_clk(core_clk), .rst_b(rst_b), .restart(restart), .restart_pc(restart_pc),
    .adv_decode(adv_decode), .adv_imm(adv_imm), .step_ack(step_ack),
    .wr_psw(wr_psw), .wr_ccr(wr_ccr), .wr_pc(wr_pc), .wr_mmu(wr_mmu),
    .pc_wr_data(pc_wr_data), .mmu_control_status(mmu_control_status),
    .mmu_vaddr(mmu_vaddr), .mmu_paddr(mmu_paddr), .bus_fetch(bus_fetch),
    .bus_addr(bus_addr), .mem_rdy(mem_rdy), .mem_rdata(mem_rdata),
    .predecode_strobe(predecode_strobe), .pipe_synced(pipe_synced),
    .pipe_steady(pipe_steady), .pc(pc), .fault_pc_snapshot_reg(fault_pc_snapshot_reg),
    .decode_holding_word(decode_holding_word), .scratch_word(scratch_word),
    .out_valid(out_valid), .out_ready(out_ready), .out_word(out_word),
    .out_is_imm(out_is_imm)
  );
  ipp_mem_model i_mem (
    .slow(slow), .mmu_vaddr(mmu_vaddr), .mmu_paddr(mmu_paddr), .bus_addr(bus_addr),
    .mem_rdy(mem_rdy), .mem_rdata(mem_rdata)
  );
  // Clock and hang limit
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      final_report;
    end
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc;
    @(posedge core_clk);
    #2;
  endtask
  // One step, plain or immediate, judged against the word stream
  task automatic step(input logic imm);
    adv_decode = !imm;
    adv_imm = imm;
    #1;
    chk("ack", 1, step_ack);
    chk("fetch", 1, bus_fetch);
    chk("strobe", !imm, predecode_strobe);
    cyc;
    if (imm) chk("scratch", p ^ 16'h5a5a, scratch_word);
    else exp_dec = p ^ 16'h5a5a;
    if (!imm && mmu_control_status[15:13] == 3'h0) exp_snap = p;
    chk("imm", imm, out_is_imm);
    chk("decode", exp_dec, decode_holding_word);
    chk("snap", exp_snap, fault_pc_snapshot_reg);
    p = p + 16'h2;
    chk("pc", p, pc);
    chk("vaddr", p + 16'h4, mmu_vaddr);
    chk("paddr", {6'h01, p + 16'h2}, bus_addr);
  endtask
  // Empty pipe: copy, translate, fetch, then first decode
  task automatic fill(input logic [15:0] p0);
    p = p0;
    chk("synced", 0, pipe_synced);
    cyc;
    chk("synced", 0, pipe_synced);
    cyc;
    chk("synced", 1, pipe_synced);
    chk("vaddr", p0 + 16'h2, mmu_vaddr);
    chk("paddr", {6'h01, p0}, bus_addr);
    cyc;
    step(0);
  endtask
  // Each register write drops the buffer word; refill takes two cycles
  task automatic faults;
    for (int k = 0; k < 4; k++) begin
      {wr_psw, wr_ccr, wr_pc, wr_mmu} = 4'h8 >> k;
      pc_wr_data = p;
      adv_decode = 1;
      #1;
      chk("ack", 0, step_ack);
      cyc;
      {wr_psw, wr_ccr, wr_pc, wr_mmu} = 4'h0;
      adv_decode = 0;
      chk("steady", 0, pipe_steady);
      chk("synced", 1, pipe_synced);
      #1;
      chk("fetch", 1, bus_fetch);
      cyc;
      chk("steady", 1, pipe_steady);
      step(0);
    end
  endtask
  // Receiver stalls until the buffer refuses, slow memory refuses, then drain
  task automatic stall;
    out_ready = 0;
    step(0);
    step(0);
    #1;
    chk("ack", 0, step_ack);
    slow = 1;
    out_ready = 1;
    #1;
    chk("ack", 0, step_ack);
    chk("word", (p - 16'h4) ^ 16'h5a5a, out_word);
    cyc;
    chk("word", (p - 16'h2) ^ 16'h5a5a, out_word);
    cyc;
    chk("valid", 0, out_valid);
    slow = 0;
    adv_decode = 0;
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge core_clk);
    #2;
    rst_b = 1;
    fill(16'h0);
    step(1);
    step(0);
    step(0);
    mmu_control_status = 16'he000;
    step(0);
    mmu_control_status = 16'h1fff;
    step(0);
    faults;
    adv_decode = 0;
    cyc;
    stall;
    cyc;
    restart_pc = 16'h0100;
    restart = 1;
    adv_decode = 1;
    #1;
    chk("ack", 0, step_ack);
    cyc;
    restart = 0;
    fill(16'h0100);
    final_report;
  end
endmodule
